// file: bench/iop_pins.sv
// switch bank on the input pins; the bench sets the levels
`timescale 1ns/100ps
module iop_pins (
   // pins
   output logic [3:0] in_line
);
   initial in_line = 4'h0;
   task set_lines(logic [3:0] v);
      in_line = v;
   endtask
endmodule

// file: bench/iop_port_chk.sv
// port block assertions; sees only iop_port ports, bound below
`timescale 1ns/100ps
module iop_port_chk (
   // ports
   input wire ref_clk, reset, mem_rd, mem_wr, out_bit_0, out_bit_1,
   input wire buzzer_enable, divclk_out_enable, input_irq_req,
   input wire [7:0] mem_addr,
   input wire [3:0] mem_wdata, mem_rdata
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_wr; mem_wr && mem_addr == 8'hF3; endsequence
   AST_PIN:
      assert property (s_wr |-> ##2 out_bit_0 == $past(mem_wdata[0], 2)) else $error("pin");
   AST_HOLD:
      assert property ($changed(out_bit_1) |-> $past(mem_wr, 2)) else $error("hold");
   AST_BUZ:
      assert property (buzzer_enable == out_bit_1) else $error("buz");
   AST_DIV:
      assert property (divclk_out_enable == out_bit_0) else $error("div");
   AST_BACK:
      assert property (mem_rd && mem_addr == 8'hF3 |=> mem_rdata == {2'h0, out_bit_1, out_bit_0})
         else $error("back");
   AST_HIGH:
      assert property (mem_rd && mem_addr == 8'hED |=> mem_rdata[3:1] == 3'h0) else $error("hi");
   AST_RST:
      assert property (disable iff (1'b0) reset |=> !out_bit_0 && !input_irq_req)
         else $error("rst");
   AST_STAND:
      assert property (!mem_rd |=> $stable(mem_rdata)) else $error("stand");
endmodule
bind iop_port iop_port_chk u_iop_port_chk (.*);

// file: bench/test_input_output_port_regs.sv
// bench for the port block; pins from iop_pins, checker bound
`timescale 1ns/100ps
module test_input_output_port_regs;
   logic ref_clk = 0, reset = 1, mem_rd = 0, mem_wr = 0;
   logic [7:0] mem_addr = 8'h00;
   logic [3:0] mem_wdata = 4'h0;
   wire [3:0] mem_rdata, in_line;
   wire out_bit_0, out_bit_1, buzzer_enable, divclk_out_enable, input_irq_req;
   int fail_count = 0, comparisons = 0;
   always #5 ref_clk = ~ref_clk;
   iop_pins u_iop_pins (.*);
   iop_port u_iop_port (.*);
   task chk(logic [7:0] a, logic [3:0] s, e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH reg %h exp %h got %h", a, e, s);
      end
   endtask
   task acc(logic w, logic [7:0] a, logic [3:0] d);
      @(posedge ref_clk);
      #1 {mem_wr, mem_rd, mem_addr, mem_wdata} = {w, !w, a, d};
      @(posedge ref_clk);
      #1 {mem_wr, mem_rd} = 2'h0;
      if (!w) chk(a, mem_rdata, d);
   endtask
   task t_out;
      acc(0, 8'hF3, 4'h0);
      chk(8'hF3, {2'h0, out_bit_1, out_bit_0}, 4'h0);
      for (int i = 0; i < 4; i++) begin
         acc(1, 8'hF3, 4'hC | i[3:0]);
         acc(0, 8'hF3, i[3:0]);
         chk(8'hF3, {2'h0, out_bit_1, out_bit_0}, i[3:0]);
         chk(8'hF3, {2'h0, buzzer_enable, divclk_out_enable}, i[3:0]);
      end
      $display("out done");
   endtask
   task t_in;
      u_iop_pins.set_lines(4'hA);
      acc(1, 8'hE0, 4'h5);
      repeat (8) @(posedge ref_clk);
      acc(0, 8'hE0, 4'hA);
      acc(0, 8'hE1, 4'h0);
      acc(0, 8'hED, 4'h0);
      acc(1, 8'hE8, 4'h1);
      u_iop_pins.set_lines(4'hB);
      repeat (8) @(posedge ref_clk);
      acc(0, 8'hED, 4'h1);
      chk(8'h00, {3'h0, input_irq_req}, 4'h1);
      acc(0, 8'hED, 4'h0);
      acc(0, 8'hE8, 4'h1);
      $display("in done");
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      #1 reset = 0;
      t_out;
      t_in;
      complete_run;
   end
endmodule

// file: core/iop_edge.v
// rising-edge detector with mask for one input line
// assumes synchronised level on ref_clk
`timescale 1ns/100ps
module iop_edge (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // line and enable
   input wire level,
   input wire enable,
   output wire hit
);
   reg last;
   always @(posedge ref_clk) begin
      if (reset) begin
         last <= 1'b0;
      end else begin
         last <= level;
      end
   end
   // masked rising edge
   assign hit = enable & level & ~last;
endmodule

// file: core/iop_port.v
// memory-mapped input port, mask, factor flag and output latch
// assumes cpu gives one 4-bit access per strobe on internal data memory
`timescale 1ns/100ps
`include "iop_regs.vh"
module iop_port #(
   parameter LINES = 4
) (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // cpu data memory access
   input wire [7:0] mem_addr,
   input wire mem_rd,
   input wire mem_wr,
   input wire [3:0] mem_wdata,
   output reg [3:0] mem_rdata,
   // input pins
   input wire [LINES-1:0] in_line,
   // output pins and special controls
   output reg out_bit_0,
   output reg out_bit_1,
   output reg buzzer_enable,
   output reg divclk_out_enable,
   // interrupt request to cpu
   output reg input_irq_req
);
   wire [LINES-1:0] level;
   wire [LINES-1:0] hit;
   reg [3:0] in_irq_en;
   reg input_irq_factor;
   reg [1:0] out_latch;
   reg [3:0] next_rdata;
   genvar i;
   generate
      for (i = 0; i < LINES; i = i + 1) begin : g_line
         iop_sync u_sync (
            .ref_clk(ref_clk),
            .reset(reset),
            .pin(in_line[i]),
            .level(level[i])
         );
         iop_edge u_edge (
            .ref_clk(ref_clk),
            .reset(reset),
            .level(level[i]),
            .enable(in_irq_en[i]),
            .hit(hit[i])
         );
      end
   endgenerate
   // write side
   always @(posedge ref_clk) begin
      if (reset) begin
         in_irq_en <= `IOP_RST_IRQ_MASK;
         out_latch <= `IOP_RST_OUTPUT_LATCH;
      end else if (mem_wr) begin
         if (mem_addr == `IOP_ADDR_IRQ_MASK) begin
            in_irq_en <= mem_wdata;
         end
         if (mem_addr == `IOP_ADDR_OUTPUT_LATCH) begin
            out_latch <= mem_wdata[1:0];
         end
      end
   end
   // factor flag, set wins over read clear
   always @(posedge ref_clk) begin
      if (reset) begin
         input_irq_factor <= `IOP_RST_IRQ_FLAG;
      end else if (|hit) begin
         input_irq_factor <= 1'b1;
      end else if (mem_rd && mem_addr == `IOP_ADDR_IRQ_FLAG) begin
         input_irq_factor <= 1'b0;
      end
   end
   // read mux
   always @* begin
      next_rdata = 4'h0;
      case (mem_addr)
         `IOP_ADDR_INPUT_LEVELS: next_rdata = level;
         `IOP_ADDR_IRQ_MASK: next_rdata = in_irq_en;
         `IOP_ADDR_IRQ_FLAG: next_rdata = {3'h0, input_irq_factor};
         `IOP_ADDR_OUTPUT_LATCH: next_rdata = {2'h0, out_latch};
         default: next_rdata = 4'h0;
      endcase
   end
   // registered outputs
   always @(posedge ref_clk) begin
      if (reset) begin
         mem_rdata <= 4'h0;
         out_bit_0 <= 1'b0;
         out_bit_1 <= 1'b0;
         buzzer_enable <= 1'b0;
         divclk_out_enable <= 1'b0;
         input_irq_req <= 1'b0;
      end else begin
         if (mem_rd) begin
            mem_rdata <= next_rdata;
         end
         out_bit_0 <= out_latch[0];
         out_bit_1 <= out_latch[1];
         buzzer_enable <= out_latch[`IOP_BIT_BUZZER];
         divclk_out_enable <= out_latch[`IOP_BIT_DIVCLK];
         input_irq_req <= input_irq_factor;
      end
   end
endmodule

// file: core/iop_regs.vh
// constants for the 4-bit input port and 2-bit output port block
// assumes an 8-bit internal data memory address and 4-bit data words
`ifndef IOP_REGS_VH
`define IOP_REGS_VH
`define IOP_ADDR_INPUT_LEVELS 8'hE0
`define IOP_ADDR_IRQ_MASK 8'hE8
`define IOP_ADDR_IRQ_FLAG 8'hED
`define IOP_ADDR_OUTPUT_LATCH 8'hF3
`define IOP_RST_IRQ_MASK 4'h0
`define IOP_RST_IRQ_FLAG 1'h0
`define IOP_RST_OUTPUT_LATCH 2'h0
`define IOP_BIT_FACTOR 0
`define IOP_BIT_DIVCLK 0
`define IOP_BIT_BUZZER 1
`endif

// file: core/iop_sync.v
// three-stage synchroniser with agreement filter for one pin
// assumes pin is asynchronous to ref_clk
`timescale 1ns/100ps
module iop_sync (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // pin and filtered level
   input wire pin,
   output reg level
);
   reg s1;
   reg s2;
   reg s3;
   always @(posedge ref_clk) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (reset) begin
         level <= 1'b0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end
endmodule
